// ---- src/oscm_defines.svh ----
// Register map, field positions, reset values and timing counts for the sensor mode control block.
// Assumes the includer compiles it once per unit; the guard protects repeated includes.
`ifndef OSCM_DEFINES_SVH
`define OSCM_DEFINES_SVH
`define OSCM_ADDR_STATUS     8'h00
`define OSCM_ADDR_MAINCFG    8'h01
`define OSCM_ADDR_AMBCFG     8'h02
`define OSCM_MAINCFG_RESET   8'h20
`define OSCM_AMBCFG_RESET    8'h00
`define OSCM_ST_AMBFLAG_BIT  0
`define OSCM_ST_PWRUP_BIT    2
`define OSCM_ST_SHDN_BIT     3
`define OSCM_ST_RESET_BIT    4
`define OSCM_MC_IRQEN_BIT    0
`define OSCM_MC_SEL_LSB      2
`define OSCM_MC_MODE_LSB     4
`define OSCM_AC_GAIN_LSB     0
`define OSCM_AC_TIM_LSB      2
`define OSCM_AC_THERMAL_SENSOR_ENABLE_BIT   5
`define OSCM_AC_INFRARED_COMPENSATION_ENABLE_BIT   6
`define OSCM_AC_TRIM_BIT     7
`define OSCM_TIM_100MS       3'h0
`define OSCM_TIM_400MS       3'h4
`define OSCM_RST_PULSE_CYC   4'h8
`define OSCM_CONV_PERIOD_CYC 24'h0f4240
`endif

// ---- src/oscm_pkg.sv ----
// Types shared by the sensor mode control block.
// Assumes nothing of its surroundings.
package oscm_pkg;
   typedef enum logic [1:0] {OSCM_SRC_CLEAR, OSCM_SRC_GREEN, OSCM_SRC_IR, OSCM_SRC_TEMP} oscm_src_t;
   typedef enum logic [1:0] {OSCM_MODE_CLEAR, OSCM_MODE_CLEAR_IR, OSCM_MODE_RGBC_IR, OSCM_MODE_RSVD} oscm_mode_t;
   // Active channel set and the settings a running conversion uses.
   typedef struct packed {
      logic clear;
      logic red;
      logic green;
      logic blue;
      logic ir;
      logic temp;
   } oscm_chan_t;
   typedef struct packed {
      oscm_chan_t chans;
      oscm_src_t  src;
      logic [1:0] gain;
      logic [2:0] tim;
      logic       infrared_compensation_enable;
   } oscm_conv_t;
   // LSB weights in quarter nW/cm2 units, so 0.5 becomes 2; blue at the top gain needs thirteen bits.
   typedef struct packed {
      logic [11:0] base_q;
      logic [12:0] blue_q;
   } oscm_lsb_t;
endpackage

// ---- src/oscm_lsb_weight.sv ----
// LSB weight lookup from gain code and integration time.
// Assumes settings are stable during the cycle they are read.
`timescale 1ns/10ps
`default_nettype none
`include "oscm_defines.svh"
module oscm_lsb_weight (
   input  wire logic [1:0]        gain_in,
   input  wire logic [2:0]        tim_in,
   output oscm_pkg::oscm_lsb_t    lsb_out
);
   logic [11:0] w100_q;
   logic [11:0] scaled_q;
   always_comb begin
      unique case (gain_in)
         2'h0: w100_q = 12'h008;
         2'h1: w100_q = 12'h020;
         2'h2: w100_q = 12'h080;
         2'h3: w100_q = 12'h800;
      endcase
   end
   // The 400 ms setting divides by four; other timings report the 100 ms scale.
   always_comb begin
      if (tim_in == `OSCM_TIM_400MS) begin
         scaled_q = w100_q >> 2;
      end else begin
         scaled_q = w100_q;
      end
      lsb_out.base_q = scaled_q;
      lsb_out.blue_q = {scaled_q, 1'b0};
   end
endmodule
`default_nettype wire

// ---- src/oscm_ctrl.sv ----
// Control and configuration registers of a multi-channel optical and temperature sensor.
// Assumes a serial bus front end delivering single-cycle register read and write strobes.
`timescale 1ns/10ps
`default_nettype none
`include "oscm_defines.svh"
// Notes on behaviour
// - Writing one to status bit 4 forces power-on reset and internal reset pulse.
// - The reset bit clears itself once the forced sequence ends.
// - Completion of forced reset raises the power-up flag.
// - Main configuration mode and source writes take effect only at the next conversion period; the interrupt enable acts at once.
// - With ambient interrupt disabled, the flag is held and forced to zero.
// - With enable set, an ambient event sets status bit 0 and pulls interrupt low.
// - Reading status clears the ambient flag and releases the interrupt.
// - Source select routes clear, green, infrared or temperature to the comparator.
// - Channel mode picks clear, clear plus infrared, or all colours plus infrared.
// - Temperature channel is active only while the thermal enable bit is one.
// - Ambient configuration write aborts conversion, applies settings, restarts conversion.
// - Gain applies to clear, red, green, blue and infrared, not temperature.
// - At 100 ms, gains give 2, 8, 32, 512 nW/cm2; blue doubles.
// - At 400 ms, every weight is one quarter of the 100 ms value.
// - Interrupt goes low one cycle after the power-up or ambient flag is set, and stays low while either is set.
// - Ambient event comes from the persist comparator; a status read, the disable, shutdown or a forced reset clears it.
module oscm_ctrl #(
   parameter int CONV_PERIOD_CYC = `OSCM_CONV_PERIOD_CYC
) (
   input  wire logic              mclk_in,
   input  wire logic              rst_b_in,
   input  wire logic [7:0]        reg_addr_in,
   input  wire logic [7:0]        reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   input  wire logic              amb_event_in,
   output logic [7:0]             reg_rdata_out,
   output logic                   irq_b_out,
   output logic                   core_reset_out,
   output logic                   shutdown_out,
   output logic                   conv_start_out,
   output oscm_pkg::oscm_conv_t   conv_cfg_out,
   output oscm_pkg::oscm_lsb_t    lsb_out,
   output logic                   trim_enable_out
);
   initial begin
      if (CONV_PERIOD_CYC < 2 || CONV_PERIOD_CYC > 24'hffffff) begin
         $error("CONV_PERIOD_CYC out of range");
      end
   end

   logic [7:0]  main_cfg_reg;
   logic [7:0]  amb_cfg_reg;
   logic        ambient_irq_flag_reg;
   logic        power_up_flag_reg;
   logic        shdn_reg;
   logic        reset_ctl_reg;
   logic [3:0]  rst_cnt_reg;
   logic [23:0] period_cnt_reg;
   logic        ambient_irq_enable;
   logic        st_wr;
   logic        st_rd;
   logic        mc_wr;
   logic        ac_wr;
   logic        force_rst;
   logic        rst_done;
   logic        period_end;
   oscm_pkg::oscm_conv_t conv_next;
   oscm_pkg::oscm_lsb_t  lsb_next;

   assign st_wr = reg_wr_in && reg_addr_in == `OSCM_ADDR_STATUS;
   assign st_rd = reg_rd_in && reg_addr_in == `OSCM_ADDR_STATUS;
   assign mc_wr = reg_wr_in && reg_addr_in == `OSCM_ADDR_MAINCFG;
   assign ac_wr = reg_wr_in && reg_addr_in == `OSCM_ADDR_AMBCFG;
   assign force_rst = st_wr && reg_wdata_in[`OSCM_ST_RESET_BIT];
   assign rst_done = reset_ctl_reg && rst_cnt_reg == 4'h1;
   assign ambient_irq_enable = main_cfg_reg[`OSCM_MC_IRQEN_BIT];
   assign period_end = period_cnt_reg == 24'h000000;

   // The forced sequence holds the internal reset pulse for a fixed count, then drops the bit.
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         reset_ctl_reg  <= 1'b0;
         rst_cnt_reg    <= 4'h0;
         core_reset_out <= 1'b0;
      end else if (force_rst && !reset_ctl_reg) begin
         reset_ctl_reg  <= 1'b1;
         rst_cnt_reg    <= `OSCM_RST_PULSE_CYC;
         core_reset_out <= 1'b1;
      end else if (reset_ctl_reg) begin
         rst_cnt_reg <= rst_cnt_reg - 4'h1;
         if (rst_done) begin
            reset_ctl_reg  <= 1'b0;
            core_reset_out <= 1'b0;
         end
      end
   end

   // Configuration returns to power-on values when the forced sequence completes.
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in || rst_done) begin
         main_cfg_reg <= `OSCM_MAINCFG_RESET;
         amb_cfg_reg  <= `OSCM_AMBCFG_RESET;
         shdn_reg     <= 1'b0;
      end else if (!reset_ctl_reg) begin
         if (mc_wr) begin
            main_cfg_reg <= reg_wdata_in;
         end
         if (ac_wr) begin
            amb_cfg_reg <= reg_wdata_in;
         end
         if (st_wr) begin
            shdn_reg <= reg_wdata_in[`OSCM_ST_SHDN_BIT];
         end
      end
   end

   // Power-up flag: set at reset release and after forced reset; set beats a clearing read.
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         power_up_flag_reg <= 1'b1;
      end else if (rst_done) begin
         power_up_flag_reg <= 1'b1;
      end else if (st_rd) begin
         power_up_flag_reg <= 1'b0;
      end
   end

   // Ambient flag: the disable forces zero, an event wins over a clearing read.
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in || rst_done) begin
         ambient_irq_flag_reg <= 1'b0;
      end else if (!ambient_irq_enable || shdn_reg) begin
         ambient_irq_flag_reg <= 1'b0;
      end else if (amb_event_in) begin
         ambient_irq_flag_reg <= 1'b1;
      end else if (st_rd) begin
         ambient_irq_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         irq_b_out <= 1'b1;
      end else begin
         irq_b_out <= !(power_up_flag_reg || ambient_irq_flag_reg);
      end
   end

   // Channel set and routing derived from the live registers.
   always_comb begin
      conv_next = '0;
      unique case (oscm_pkg::oscm_mode_t'(main_cfg_reg[`OSCM_MC_MODE_LSB +: 2]))
         oscm_pkg::OSCM_MODE_CLEAR: begin
            conv_next.chans.clear = 1'b1;
         end
         oscm_pkg::OSCM_MODE_CLEAR_IR: begin
            conv_next.chans.clear = 1'b1;
            conv_next.chans.ir    = 1'b1;
         end
         oscm_pkg::OSCM_MODE_RGBC_IR: begin
            conv_next.chans.clear = 1'b1;
            conv_next.chans.red   = 1'b1;
            conv_next.chans.green = 1'b1;
            conv_next.chans.blue  = 1'b1;
            conv_next.chans.ir    = 1'b1;
         end
         oscm_pkg::OSCM_MODE_RSVD: begin
            conv_next.chans.clear = 1'b0;
         end
      endcase
      conv_next.chans.temp = amb_cfg_reg[`OSCM_AC_THERMAL_SENSOR_ENABLE_BIT];
      conv_next.src    = oscm_pkg::oscm_src_t'(main_cfg_reg[`OSCM_MC_SEL_LSB +: 2]);
      conv_next.gain   = amb_cfg_reg[`OSCM_AC_GAIN_LSB +: 2];
      conv_next.tim    = amb_cfg_reg[`OSCM_AC_TIM_LSB +: 3];
      conv_next.infrared_compensation_enable = amb_cfg_reg[`OSCM_AC_INFRARED_COMPENSATION_ENABLE_BIT];
   end

   oscm_lsb_weight u_lsb (
      .gain_in (conv_next.gain),
      .tim_in  (conv_next.tim),
      .lsb_out (lsb_next)
   );

   // Period counter; an ambient write restarts it so a fresh conversion begins now.
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in || reset_ctl_reg || shdn_reg) begin
         period_cnt_reg <= 24'h000000;
         conv_start_out <= 1'b0;
      end else if (ac_wr || period_end) begin
         period_cnt_reg <= 24'(CONV_PERIOD_CYC - 1);
         conv_start_out <= 1'b1;
      end else begin
         period_cnt_reg <= period_cnt_reg - 24'h000001;
         conv_start_out <= 1'b0;
      end
   end

   // Settings are latched only at a conversion start, so main writes wait for the next period.
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         conv_cfg_out    <= '0;
         lsb_out         <= '0;
         trim_enable_out <= 1'b0;
      end else if (conv_start_out) begin
         conv_cfg_out    <= conv_next;
         lsb_out         <= lsb_next;
         trim_enable_out <= amb_cfg_reg[`OSCM_AC_TRIM_BIT];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         shutdown_out <= 1'b0;
      end else begin
         shutdown_out <= shdn_reg;
      end
   end

   // Read data appears one cycle after the strobe; unmapped addresses return zero.
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            `OSCM_ADDR_STATUS: reg_rdata_out <= {3'h0, reset_ctl_reg, shdn_reg, power_up_flag_reg,
                                                 1'b0, ambient_irq_flag_reg};
            `OSCM_ADDR_MAINCFG: reg_rdata_out <= main_cfg_reg;
            `OSCM_ADDR_AMBCFG: reg_rdata_out <= amb_cfg_reg;
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // Cycles since the last conversion start; only the period check below reads it.
   logic [23:0] gap_cnt_reg;
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in || conv_start_out || reset_ctl_reg || shdn_reg) begin
         gap_cnt_reg <= 24'h000000;
      end else begin
         gap_cnt_reg <= gap_cnt_reg + 24'h000001;
      end
   end

   // The interrupt output lags its flags by one edge, so the first edge after reset is exempt.
   flag_disable_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !ambient_irq_enable |=> !ambient_irq_flag_reg) else $error("ambient flag set while disabled");
   event_sets_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      ambient_irq_enable && amb_event_in && !shdn_reg && !rst_done |=> ambient_irq_flag_reg ##1 !irq_b_out)
      else $error("event did not set flag and irq");
   event_wins_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      ambient_irq_enable && amb_event_in && st_rd && !shdn_reg && !rst_done |=> ambient_irq_flag_reg)
      else $error("status read beat a same-cycle event");
   read_clears_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      st_rd && !amb_event_in |=> !ambient_irq_flag_reg) else $error("status read left flag set");
   irq_follows_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      $past(rst_b_in) |-> irq_b_out == !$past(power_up_flag_reg || ambient_irq_flag_reg))
      else $error("irq mismatch");
   reset_pulse_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      force_rst && !reset_ctl_reg |=> core_reset_out [*8] ##1 !reset_ctl_reg && power_up_flag_reg)
      else $error("forced reset sequence wrong");
   wr_ignored_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      reset_ctl_reg && !rst_done |=> $stable(main_cfg_reg) && $stable(amb_cfg_reg))
      else $error("configuration written during forced reset");
   self_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      $rose(reset_ctl_reg) |-> ##[1:9] !reset_ctl_reg) else $error("reset bit stuck");
   pwrup_after_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      rst_done |=> power_up_flag_reg && main_cfg_reg == `OSCM_MAINCFG_RESET) else $error("no power-up flag");
   main_defer_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !conv_start_out |=> $stable(conv_cfg_out)) else $error("config changed mid conversion");
   period_len_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      gap_cnt_reg < 24'(CONV_PERIOD_CYC)) else $error("conversion period overran");
   amb_restart_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      ac_wr && !reset_ctl_reg && !shdn_reg |=> conv_start_out) else $error("no restart on ambient write");
   src_route_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      conv_start_out |=> conv_cfg_out.src == $past(main_cfg_reg[`OSCM_MC_SEL_LSB +: 2]))
      else $error("interrupt source not routed");
   temp_route_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      conv_start_out |=> conv_cfg_out.chans.temp == $past(amb_cfg_reg[`OSCM_AC_THERMAL_SENSOR_ENABLE_BIT]))
      else $error("temperature channel does not follow its enable");
   mode_set_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      conv_start_out && main_cfg_reg[`OSCM_MC_MODE_LSB +: 2] == 2'h2 |=> conv_cfg_out.chans[5:1] == 5'h1f)
      else $error("full colour mode missing channels");
   gain_100_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      conv_cfg_out.tim == `OSCM_TIM_100MS && conv_cfg_out.gain == 2'h3 |->
      lsb_out.base_q == 12'h800 && lsb_out.blue_q == 13'h1000) else $error("top gain weight wrong");
   gain_400_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      conv_cfg_out.tim == `OSCM_TIM_400MS && conv_cfg_out.gain == 2'h0 |->
      lsb_out.base_q == 12'h002 && lsb_out.blue_q == 13'h0004) else $error("long integration weight wrong");

   // Covers mark the scenarios that the bench is expected to reach.
   forced_reset_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in) rst_done);
   amb_irq_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in) ambient_irq_flag_reg && st_rd);
   restart_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in) ac_wr && !period_end);
   event_read_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in) amb_event_in && st_rd && ambient_irq_enable);
   main_defer_c: cover property (@(posedge mclk_in) disable iff (!rst_b_in) mc_wr && !conv_start_out);
endmodule
`default_nettype wire

// ---- tb/oscm_host.sv ----
// Host model that drives the register bus of the sensor mode control block.
// Assumes one clock; requests change on the falling edge and are taken on the next rising edge.
`timescale 1ns/10ps
`default_nettype none
module oscm_host (
   input  wire logic       mclk_in,
   input  wire logic [7:0] reg_rdata_in,
   output logic [7:0]      reg_addr_out,
   output logic [7:0]      reg_wdata_out,
   output logic            reg_wr_out,
   output logic            reg_rd_out
);
   initial begin
      reg_addr_out = 8'h5a;
      reg_wdata_out = 8'ha5;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end
   // Released lines show the inverse of the last value so stale data never looks valid.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(negedge mclk_in);
      reg_wr_out = 1'b0;
      reg_addr_out = ~a;
      reg_wdata_out = ~d;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk_in);
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(negedge mclk_in);
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
      d = reg_rdata_in;
   endtask
endmodule
`default_nettype wire

// ---- tb/optical_sensor_mode_ctrl_tb.sv ----
// Self-checking bench for the sensor mode control block.
// Assumes the host model drives the register bus and the bench drives the event input.
`timescale 1ns/10ps
`default_nettype none
`include "oscm_defines.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module optical_sensor_mode_ctrl_tb;
   logic                 mclk;
   logic                 rst_b;
   logic                 amb_event;
   logic [7:0]           addr, wdata, rdata, d;
   logic                 wr, rd, irq_b, core_reset, conv_start, shdn, trim;
   oscm_pkg::oscm_conv_t cfg;
   oscm_pkg::oscm_lsb_t  lsb;
   oscm_pkg::oscm_chan_t ch;
   int                   n_errors = 0;
   int                   n_compared = 0;
   int                   w;
   oscm_ctrl #(.CONV_PERIOD_CYC(20)) dut (.mclk_in(mclk), .rst_b_in(rst_b), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .amb_event_in(amb_event),
      .reg_rdata_out(rdata), .irq_b_out(irq_b), .core_reset_out(core_reset), .shutdown_out(shdn),
      .conv_start_out(conv_start), .conv_cfg_out(cfg), .lsb_out(lsb), .trim_enable_out(trim));
   oscm_host host (.mclk_in(mclk), .reg_rdata_in(rdata), .reg_addr_out(addr),
      .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic pulse_event();
      amb_event = 1'b1;
      tick(1);
      amb_event = 1'b0;
      tick(2);
   endtask
   task automatic t_reset_values();
      `CHK(irq_b, 1'b0);
      host.read_reg(`OSCM_ADDR_STATUS, d);
      `CHK(d, 8'h04);
      tick(1);
      `CHK(irq_b, 1'b1);
      host.read_reg(`OSCM_ADDR_MAINCFG, d);
      `CHK(d, 8'h20);
      host.read_reg(`OSCM_ADDR_AMBCFG, d);
      `CHK(d, 8'h00);
      host.read_reg(8'h07, d);
      `CHK(d, 8'h00);
   endtask
   task automatic t_irq();
      host.write_reg(`OSCM_ADDR_MAINCFG, 8'h21);
      pulse_event();
      `CHK(irq_b, 1'b0);
      tick(5);
      `CHK(irq_b, 1'b0);
      host.read_reg(`OSCM_ADDR_STATUS, d);
      `CHK(d, 8'h01);
      tick(1);
      `CHK(irq_b, 1'b1);
      // An event in the same cycle as the clearing read must survive it.
      fork
         host.read_reg(`OSCM_ADDR_STATUS, d);
         begin
            tick(1);
            amb_event = 1'b1;
            tick(1);
            amb_event = 1'b0;
         end
      join
      `CHK(d, 8'h00);
      tick(1);
      `CHK(irq_b, 1'b0);
      pulse_event();
      host.write_reg(`OSCM_ADDR_MAINCFG, 8'h20);
      tick(2);
      `CHK(irq_b, 1'b1);
      pulse_event();
      `CHK(irq_b, 1'b1);
      host.read_reg(`OSCM_ADDR_STATUS, d);
      `CHK(d, 8'h00);
   endtask
   // Each source is paired with a mode that keeps that channel live.
   task automatic t_modes();
      logic [1:0] s;
      for (int i = 0; i < 4; i++) begin
         s = (i == 1) ? 2'h2 : (i == 2) ? 2'h1 : 2'(i);
         ch = '{1'b1, i % 3 == 2, i % 3 == 2, i % 3 == 2, i % 3 != 0, i[0]};
         host.write_reg(`OSCM_ADDR_MAINCFG, 8'(((i % 3) << 4) | (s << 2)));
         host.write_reg(`OSCM_ADDR_AMBCFG, 8'(i[0] << 5));
         `CHK(conv_start, 1'b1);
         tick(1);
         `CHK(cfg.chans, ch);
         `CHK(cfg.src, s);
         host.write_reg(`OSCM_ADDR_MAINCFG, 8'h00);
         tick(3);
         `CHK(cfg.chans, ch);
         tick(20);
         `CHK(cfg.chans, oscm_pkg::oscm_chan_t'({5'h10, i[0]}));
      end
   endtask
   task automatic t_lsb();
      for (int k = 0; k < 8; k++) begin
         host.write_reg(`OSCM_ADDR_AMBCFG, 8'((k[2] ? 16 : 0) | k[1:0] | (k[1] << 6) | (k[0] << 7)));
         tick(2);
         w = (k[1:0] == 2'h3) ? 2048 : (8 << (2 * k[1:0]));
         if (k[2]) w = w / 4;
         `CHK(lsb.base_q, 12'(w));
         `CHK(lsb.blue_q, 13'(2 * w));
         `CHK(cfg.gain, 2'(k));
         `CHK(cfg.tim, k[2] ? `OSCM_TIM_400MS : `OSCM_TIM_100MS);
         `CHK(cfg.infrared_compensation_enable, k[1]);
         `CHK(trim, k[0]);
      end
   endtask
   task automatic t_freset();
      int cnt;
      cnt = 0;
      host.write_reg(`OSCM_ADDR_MAINCFG, 8'h15);
      host.write_reg(`OSCM_ADDR_STATUS, 8'h18);
      for (int i = 0; i < 30; i++) begin
         if (core_reset === 1'b1) cnt++;
         if (i == 4) `CHK(shdn, 1'b1);
         tick(1);
      end
      `CHK(cnt, 8);
      `CHK(shdn, 1'b0);
      host.read_reg(`OSCM_ADDR_AMBCFG, d);
      `CHK(d, 8'h00);
      `CHK(irq_b, 1'b0);
      host.read_reg(`OSCM_ADDR_MAINCFG, d);
      `CHK(d, 8'h20);
      host.read_reg(`OSCM_ADDR_STATUS, d);
      `CHK(d, 8'h04);
   endtask
   // The whole run needs well under a thousand cycles; the limit leaves a wide margin.
   initial begin
      #2000000;
      n_errors++;
      give_verdict();
   end
   initial begin
      rst_b = 1'b0;
      amb_event = 1'b0;
      tick(8);
      rst_b = 1'b1;
      tick(2);
      t_reset_values();
      t_irq();
      t_modes();
      t_lsb();
      t_freset();
      give_verdict();
   end
endmodule
`default_nettype wire
